// ### bsc_irq_map.v
`timescale 1ns/1ps
`include "bsc_map.vh"
module bsc_irq_map (
	input wire [1:0] rotation,
	input wire tie_two,
	input wire tie_all,
	input wire [2:0] irq_in,
	output reg [3:0] slot_out
);
	reg [2:0] merged;
	always @* begin
		merged = irq_in;
		if (tie_all) begin
			merged = {2'h0, |irq_in};
		end else if (tie_two) begin
			merged = {irq_in[2], 1'b0, irq_in[1] | irq_in[0]};
		end
		case (rotation)
			`BSC_ROT_ABC: slot_out = {1'b0, merged};
			`BSC_ROT_BCD1: slot_out = {merged, 1'b0};
			`BSC_ROT_BCD2: slot_out = {merged, 1'b0};
			`BSC_ROT_CDA: slot_out = {merged[1:0], 1'b0, merged[2]};
			default: slot_out = {1'b0, merged};
		endcase
	end
endmodule // bsc_irq_map

// ### bsc_map.vh
`ifndef BSC_MAP_VH
`define BSC_MAP_VH
`define BSC_OFF_SYSCTL 8'h80
`define BSC_RESET_VALUE 32'h00000020
`define BSC_ROT_HI 31
`define BSC_ROT_LO 30
`define BSC_TIE2_BIT 29
`define BSC_TIE3_BIT 28
`define BSC_CLKDIR_BIT 27
`define BSC_ROUTE_BIT 26
`define BSC_FLAG_BIT 25
`define BSC_IRQEN_BIT 24
`define BSC_RSVD23_BIT 23
`define BSC_RPIN_BIT 22
`define BSC_VPROT_BIT 21
`define BSC_RZV_BIT 20
`define BSC_DREQEN_BIT 19
`define BSC_CHAN_HI 18
`define BSC_CHAN_LO 16
`define BSC_LOW_HI 15
`define BSC_LOW_RESET 16'h0020
`define BSC_ROT_ABC 2'h0
`define BSC_ROT_BCD1 2'h1
`define BSC_ROT_BCD2 2'h2
`define BSC_ROT_CDA 2'h3
`define BSC_PIN_INTA 8'h01
`define BSC_PIN_INTB 8'h02
`define BSC_PIN_INTC 8'h03
`endif

// ### bsc_sysctl.v
`timescale 1ns/1ps
`include "bsc_map.vh"
module bsc_sysctl (
	input wire clk,
	input wire rst_n,
	input wire glob_rst_n,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire cfg_func,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_hit,
	input wire [1:0] power_write_strobe,
	input wire [2:0] internal_irq,
	input wire [1:0] card_inserted,
	input wire [1:0] card_dma_req,
	output reg [3:0] irq_slot,
	output reg [7:0] irq_pin_value,
	output reg switch_clock_direction,
	output reg [1:0] power_write_irq_isa2,
	output reg [1:0] card_status_change_irq,
	output reg [1:0] reserved_pin_drive_low,
	output reg [1:0] reserved_pin_oe,
	output reg [1:0] supply_protect_disable,
	output reg card_addr_float,
	output reg [1:0] card_dma_request,
	output reg [2:0] card_dma_channel
);
	reg [1:0] interrupt_slot_rotation_reg;
	reg tie_first_two_interrupts_reg;
	reg tie_three_interrupts_reg;
	reg switch_clock_direction_reg;
	reg power_write_irq_route_reg;
	reg [1:0] power_write_flag_reg;
	reg power_write_irq_enable_reg;
	reg reserved_pin_drive_reg;
	reg [1:0] supply_protect_disable_reg;
	reg reduced_video_reg;
	reg card_dma_request_enable_reg;
	reg [2:0] card_dma_channel_reg;
	reg [15:0] low_half_reg;
	reg [1:0] ins_s1_reg;
	reg [1:0] ins_s2_reg;
	reg [1:0] dreq_s1_reg;
	reg [1:0] dreq_s2_reg;
	reg [2:0] irq_s1_reg;
	reg [2:0] irq_s2_reg;
	wire [3:0] slot_next;
	wire sel;
	wire wr_hi;
	wire wr_lo;
	wire [1:0] flag_clr;
	wire [1:0] flag_set;
	wire wr_b1;
	wire wr_b0;
	wire [1:0] isa2_next;
	wire [1:0] csc_next;
	wire [1:0] oe_next;
	wire [1:0] dreq_next;
	// one byte lane of this doubleword is written in this cycle
	function lane_wr;
		input wr;
		input hit;
		input [3:0] be;
		input [1:0] lane;
		begin
			lane_wr = wr & hit & be[lane];
		end
	endfunction
	assign sel = (cfg_addr == `BSC_OFF_SYSCTL);
	assign wr_hi = lane_wr(cfg_wr, sel, cfg_be, 2'h3);
	assign wr_lo = lane_wr(cfg_wr, sel, cfg_be, 2'h2);
	assign wr_b1 = lane_wr(cfg_wr, sel, cfg_be, 2'h1);
	assign wr_b0 = lane_wr(cfg_wr, sel, cfg_be, 2'h0);
	// both functions map the same register; global bits are shared by construction
	// clear is per function socket; a simultaneous set still wins
	assign flag_clr = {cfg_func, ~cfg_func} & {2{wr_hi & cfg_wdata[`BSC_FLAG_BIT]}};
	assign flag_set = power_write_strobe & {2{power_write_irq_enable_reg}};
	// per-socket fan-out keeps each socket's pulse on exactly one route
	genvar sock;
	generate
		for (sock = 0; sock < 2; sock = sock + 1) begin : g_sock
			assign isa2_next[sock] = flag_set[sock] & ~power_write_irq_route_reg;
			assign csc_next[sock] = flag_set[sock] & power_write_irq_route_reg;
			// pins float unless a card sits in the socket and the drive bit is set
			assign oe_next[sock] = ins_s2_reg[sock] & reserved_pin_drive_reg;
			assign dreq_next[sock] = dreq_s2_reg[sock] & card_dma_request_enable_reg;
		end
	endgenerate
	// global bits only see the global reset, not the bus reset
	always @(posedge clk) begin
		if (!glob_rst_n) begin
			interrupt_slot_rotation_reg <= 2'h0;
			tie_first_two_interrupts_reg <= 1'b0;
			switch_clock_direction_reg <= 1'b0;
			power_write_irq_route_reg <= 1'b0;
			power_write_flag_reg <= 2'h0;
			power_write_irq_enable_reg <= 1'b0;
			reserved_pin_drive_reg <= 1'b0;
			supply_protect_disable_reg <= 2'h0;
			reduced_video_reg <= 1'b0;
			card_dma_request_enable_reg <= 1'b0;
			card_dma_channel_reg <= 3'h0;
			low_half_reg <= `BSC_LOW_RESET;
		end else begin
			power_write_flag_reg <= (power_write_flag_reg & ~flag_clr) | flag_set;
			if (wr_hi) begin
				interrupt_slot_rotation_reg <= cfg_wdata[`BSC_ROT_HI:`BSC_ROT_LO];
				tie_first_two_interrupts_reg <= cfg_wdata[`BSC_TIE2_BIT];
				switch_clock_direction_reg <= cfg_wdata[`BSC_CLKDIR_BIT];
				power_write_irq_route_reg <= cfg_wdata[`BSC_ROUTE_BIT];
				power_write_irq_enable_reg <= cfg_wdata[`BSC_IRQEN_BIT];
			end
			if (wr_lo) begin
				reserved_pin_drive_reg <= cfg_wdata[`BSC_RPIN_BIT];
				if (cfg_func) begin
					supply_protect_disable_reg[1] <= cfg_wdata[`BSC_VPROT_BIT];
				end else begin
					supply_protect_disable_reg[0] <= cfg_wdata[`BSC_VPROT_BIT];
				end
				reduced_video_reg <= cfg_wdata[`BSC_RZV_BIT];
				card_dma_request_enable_reg <= cfg_wdata[`BSC_DREQEN_BIT];
				card_dma_channel_reg <= cfg_wdata[`BSC_CHAN_HI:`BSC_CHAN_LO];
			end
			if (wr_b1) begin
				low_half_reg[15:8] <= cfg_wdata[15:8];
			end
			if (wr_b0) begin
				low_half_reg[7:0] <= cfg_wdata[7:0];
			end
		end
	end
	// bit 28 is not marked global, so the bus reset clears it
	always @(posedge clk) begin
		// either reset clears it
		if (!rst_n || !glob_rst_n) begin
			tie_three_interrupts_reg <= 1'b0;
		end else if (wr_hi) begin
			tie_three_interrupts_reg <= cfg_wdata[`BSC_TIE3_BIT];
		end
	end
	bsc_irq_map u_map (
		.rotation(interrupt_slot_rotation_reg),
		.tie_two(tie_first_two_interrupts_reg),
		.tie_all(tie_three_interrupts_reg),
		.irq_in(irq_s2_reg),
		.slot_out(slot_next)
	);
	always @(posedge clk) begin
		if (!rst_n) begin
			ins_s1_reg <= 2'h0;
			ins_s2_reg <= 2'h0;
			dreq_s1_reg <= 2'h0;
			dreq_s2_reg <= 2'h0;
			irq_s1_reg <= 3'h0;
			irq_s2_reg <= 3'h0;
			cfg_rdata <= 32'h00000000;
			cfg_hit <= 1'b0;
			irq_slot <= 4'h0;
			irq_pin_value <= `BSC_PIN_INTA;
			switch_clock_direction <= 1'b0;
			power_write_irq_isa2 <= 2'h0;
			card_status_change_irq <= 2'h0;
			reserved_pin_drive_low <= 2'h0;
			reserved_pin_oe <= 2'h0;
			supply_protect_disable <= 2'h0;
			card_addr_float <= 1'b0;
			card_dma_request <= 2'h0;
			card_dma_channel <= 3'h0;
		end else begin
			// two stages first, socket pins are not on this clock
			ins_s1_reg <= card_inserted;
			ins_s2_reg <= ins_s1_reg;
			dreq_s1_reg <= card_dma_req;
			dreq_s2_reg <= dreq_s1_reg;
			irq_s1_reg <= internal_irq;
			irq_s2_reg <= irq_s1_reg;
			cfg_hit <= (cfg_rd | cfg_wr) & sel;
			// unmapped reads return zero
			if (cfg_rd & sel) begin
				cfg_rdata <= {interrupt_slot_rotation_reg, tie_first_two_interrupts_reg,
					tie_three_interrupts_reg, switch_clock_direction_reg, power_write_irq_route_reg,
					power_write_flag_reg[cfg_func], power_write_irq_enable_reg, 1'b0,
					reserved_pin_drive_reg, supply_protect_disable_reg[cfg_func], reduced_video_reg,
					card_dma_request_enable_reg, card_dma_channel_reg, low_half_reg};
			end else begin
				cfg_rdata <= 32'h00000000;
			end
			// slot map is combinational, the flop keeps the output glitch free
			irq_slot <= slot_next;
			// with tie-all every function reports slot A
			irq_pin_value <= (tie_three_interrupts_reg || !cfg_func) ? `BSC_PIN_INTA : `BSC_PIN_INTB;
			switch_clock_direction <= switch_clock_direction_reg;
			power_write_irq_isa2 <= isa2_next;
			card_status_change_irq <= csc_next;
			reserved_pin_drive_low <= 2'h0;
			reserved_pin_oe <= oe_next;
			supply_protect_disable <= supply_protect_disable_reg;
			card_addr_float <= reduced_video_reg;
			card_dma_request <= dreq_next;
			card_dma_channel <= card_dma_channel_reg;
		end
	end
endmodule // bsc_sysctl

// ### bsc_sysctl_props.sv
`timescale 1ns/1ps
module bsc_sysctl_props (
	input wire clk,
	input wire rst_n,
	input wire glob_rst_n,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire cfg_func,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire cfg_hit,
	input wire [1:0] power_write_strobe,
	input wire [7:0] irq_pin_value,
	input wire switch_clock_direction,
	input wire [1:0] power_write_irq_isa2,
	input wire [1:0] card_status_change_irq,
	input wire [1:0] reserved_pin_drive_low,
	input wire [1:0] card_inserted,
	input wire [1:0] reserved_pin_oe
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n || !glob_rst_n);
sequence s_acc; (cfg_rd || cfg_wr) && cfg_addr == 8'h80; endsequence
// function 0 only: global bits
sequence s_top_wr; cfg_wr && cfg_addr == 8'h80 && cfg_be[3] && !cfg_func; endsequence
property p_hit; s_acc |=> cfg_hit; endproperty
a_hit: assert property (p_hit) else $error("no hit after access");
property p_miss; (cfg_rd || cfg_wr) && cfg_addr != 8'h80 |=> !cfg_hit && cfg_rdata == 32'h00000000; endproperty
a_miss: assert property (p_miss) else $error("foreign address answered");
property p_rsvd; cfg_hit |-> !cfg_rdata[23]; endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
property p_clk; s_top_wr |-> ##2 switch_clock_direction == $past(cfg_wdata[27], 2); endproperty
a_clk: assert property (p_clk) else $error("clock direction not applied");
property p_src; power_write_irq_isa2[0] || card_status_change_irq[0] |-> $past(power_write_strobe[0]); endproperty
a_src: assert property (p_src) else $error("irq without power write");
property p_excl; !(power_write_irq_isa2[0] && card_status_change_irq[0]); endproperty
a_excl: assert property (p_excl) else $error("irq on both routes");
property p_low; reserved_pin_drive_low == 2'h0; endproperty
a_low: assert property (p_low) else $error("reserved pins not low");
property p_oe; reserved_pin_oe[0] |-> $past(card_inserted[0], 3); endproperty
a_oe: assert property (p_oe) else $error("reserved pins driven without card");
property p_pin; irq_pin_value == 8'h01 || irq_pin_value == 8'h02; endproperty
a_pin: assert property (p_pin) else $error("bad pin value");
endmodule // bsc_sysctl_props

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
reg clk = 0, rst_n = 0, glob_rst_n = 0, cfg_wr = 0, cfg_rd = 0, cfg_func = 0;
reg [7:0] cfg_addr = 8'h80;
reg [3:0] cfg_be = 4'hF;
reg [31:0] cfg_wdata = 32'h00000000;
reg [1:0] power_write_strobe = 2'h0, card_inserted = 2'h0, card_dma_req = 2'h0;
reg [2:0] internal_irq = 3'h0;
wire [31:0] cfg_rdata;
wire cfg_hit, switch_clock_direction, card_addr_float;
wire [3:0] irq_slot;
wire [7:0] irq_pin_value;
wire [1:0] power_write_irq_isa2, card_status_change_irq, reserved_pin_drive_low, reserved_pin_oe;
wire [1:0] supply_protect_disable, card_dma_request;
wire [2:0] card_dma_channel;
integer error_cnt = 0, comparisons = 0, i;
always #5 clk = ~clk;
bsc_sysctl dut (.clk(clk), .rst_n(rst_n), .glob_rst_n(glob_rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.cfg_hit(cfg_hit), .power_write_strobe(power_write_strobe), .internal_irq(internal_irq),
	.card_inserted(card_inserted), .card_dma_req(card_dma_req), .irq_slot(irq_slot),
	.irq_pin_value(irq_pin_value), .switch_clock_direction(switch_clock_direction),
	.power_write_irq_isa2(power_write_irq_isa2), .card_status_change_irq(card_status_change_irq),
	.reserved_pin_drive_low(reserved_pin_drive_low), .reserved_pin_oe(reserved_pin_oe),
	.supply_protect_disable(supply_protect_disable), .card_addr_float(card_addr_float),
	.card_dma_request(card_dma_request), .card_dma_channel(card_dma_channel));
task chk(input [31:0] got, input [31:0] exp); begin
	comparisons = comparisons + 1;
	if (got !== exp) begin
		error_cnt = error_cnt + 1;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	end
end endtask
task acc(input w, input f, input [7:0] a, input [31:0] d); begin
	@(negedge clk);
	cfg_wr = w; cfg_rd = !w; cfg_func = f; cfg_addr = a; cfg_wdata = d;
	@(negedge clk);
	cfg_wr = 0; cfg_rd = 0;
end endtask
// bounded: irq path has synchronisers
task slot(input [3:0] e); integer k; begin
	for (k = 0; k < 10 && irq_slot !== e; k = k + 1) @(negedge clk);
	chk(irq_slot, e);
	if (irq_slot !== e) report_and_stop;
end endtask
task report_and_stop; begin
	$display("errors %0d comparisons %0d", error_cnt, comparisons);
	if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
end endtask
task t_reset; begin
	acc(0, 0, 8'h80, 0); chk(cfg_rdata, 32'h00000020);
	acc(0, 1, 8'h80, 0); chk(cfg_rdata, 32'h00000020);
	acc(1, 0, 8'h84, 32'hFFFFFFFF); acc(0, 0, 8'h84, 0); chk(cfg_rdata, 0);
end endtask
task t_fields; begin
	acc(1, 0, 8'h80, 32'hFFFFFFFF); acc(0, 0, 8'h80, 0);
	chk(cfg_rdata, 32'hFD7FFFFF);
	chk({switch_clock_direction, card_addr_float, card_dma_channel, irq_pin_value, reserved_pin_oe},
		{1'b1, 1'b1, 3'h7, 8'h01, 2'h0});
end endtask
task t_rot; begin
	internal_irq = 3'h1;
	for (i = 0; i < 4; i = i + 1) begin
		acc(1, 0, 8'h80, i << 30); slot(i == 0 ? 4'h1 : i == 3 ? 4'h4 : 4'h2);
	end
	internal_irq = 3'h4;
	acc(1, 0, 8'h80, 32'h40000000); slot(4'h8);
	internal_irq = 3'h2;
	acc(1, 0, 8'h80, 32'h20000000); slot(4'h1);
	internal_irq = 3'h4;
	acc(1, 0, 8'h80, 32'hD0000000); slot(4'h4);
	internal_irq = 3'h0;
end endtask
task t_pw; begin
	for (i = 0; i < 2; i = i + 1) begin
		acc(1, 0, 8'h80, 32'h01000000 | (i << 26));
		@(negedge clk); power_write_strobe = 2'h1;
		@(negedge clk); power_write_strobe = 2'h0;
		chk({power_write_irq_isa2[0], card_status_change_irq[0]}, i ? 2'h1 : 2'h2);
		acc(0, 0, 8'h80, 0); chk(cfg_rdata[25], 1);
		acc(1, 0, 8'h80, 32'h03000000 | (i << 26)); acc(0, 0, 8'h80, 0); chk(cfg_rdata[25], 0);
	end
	acc(1, 0, 8'h80, 0);
	@(negedge clk); power_write_strobe = 2'h3;
	@(negedge clk); power_write_strobe = 2'h0;
	chk({power_write_irq_isa2, card_status_change_irq}, 4'h0);
	acc(0, 0, 8'h80, 0); chk(cfg_rdata[25], 0);
	acc(1, 0, 8'h80, 32'h01000000);
	@(negedge clk); power_write_strobe = 2'h2;
	@(negedge clk); power_write_strobe = 2'h0;
	chk({power_write_irq_isa2, card_status_change_irq}, 4'h8);
	acc(0, 1, 8'h80, 0); chk(cfg_rdata[25], 1);
	acc(0, 0, 8'h80, 0); chk(cfg_rdata[25], 0);
	@(negedge clk); cfg_wr = 1; cfg_func = 1; cfg_wdata = 32'h03000000; power_write_strobe = 2'h2;
	@(negedge clk); cfg_wr = 0; power_write_strobe = 2'h0;
	acc(0, 1, 8'h80, 0); chk(cfg_rdata[25], 1);
	acc(1, 1, 8'h80, 32'h03000000); acc(0, 1, 8'h80, 0); chk(cfg_rdata[25], 0);
end endtask
task t_sock; begin
	acc(1, 1, 8'h80, 32'h00200000); chk(irq_pin_value, 8'h02);
	acc(0, 1, 8'h80, 0); chk(cfg_rdata, 32'h00200000);
	acc(1, 0, 8'h80, 32'h00480000); acc(0, 0, 8'h80, 0); chk(cfg_rdata, 32'h00480000);
	card_inserted = 2'h1; card_dma_req = 2'h3;
	repeat (4) @(negedge clk);
	chk({supply_protect_disable, reserved_pin_oe, reserved_pin_drive_low, card_dma_request}, 8'h93);
	card_inserted = 2'h0;
	acc(1, 0, 8'h80, 32'h00400000);
	repeat (3) @(negedge clk);
	chk({reserved_pin_oe, card_dma_request}, 4'h0);
	card_dma_req = 2'h0;
end endtask
task t_glob; begin
	acc(1, 0, 8'h80, 32'h18000000);
	@(negedge clk); rst_n = 0;
	@(negedge clk); rst_n = 1;
	acc(0, 0, 8'h80, 0); chk(cfg_rdata, 32'h08000000);
	acc(1, 0, 8'h80, 32'hFFFFFFFF);
	@(negedge clk); glob_rst_n = 0;
	@(negedge clk); glob_rst_n = 1;
	acc(0, 0, 8'h80, 0); chk(cfg_rdata, 32'h00000020);
end endtask
initial begin
	repeat (3) @(posedge clk);
	@(negedge clk); rst_n = 1; glob_rst_n = 1;
	t_reset; t_fields; t_rot; t_pw; t_sock; t_glob;
	report_and_stop;
end
endmodule // tb_top
bind bsc_sysctl bsc_sysctl_props u_props (.clk(clk), .rst_n(rst_n), .glob_rst_n(glob_rst_n), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .power_write_strobe(power_write_strobe),
	.irq_pin_value(irq_pin_value), .switch_clock_direction(switch_clock_direction),
	.power_write_irq_isa2(power_write_irq_isa2), .card_status_change_irq(card_status_change_irq),
	.reserved_pin_drive_low(reserved_pin_drive_low), .card_inserted(card_inserted),
	.reserved_pin_oe(reserved_pin_oe));
